// ===== design/core_idle_decode.sv
// per-core decode of idle state into clock, pll, cache, supply and context actions
`default_nettype none
`include "pkg_idle_params.svh"
module core_idle_decode (
   // core state
   input  wire logic [`CORE_STATE_W-1:0] state_in,
   input  wire logic [`SUPPLY_W-1:0]     ret_supply_in,
   // actions
   output logic                          clk_run_out,
   output logic                          pll_on_out,
   output logic                          cache_flush_out,
   output logic                          low_freq_out,
   output logic                          power_gate_out,
   output logic                          ctx_flush_out,
   output logic [`SUPPLY_W-1:0]          supply_out
);
   // table of per-state actions; unknown codes treated as halt (safe)
   always_comb begin
      clk_run_out     = 1'b0;
      pll_on_out      = 1'b1;
      cache_flush_out = 1'b0;
      low_freq_out    = 1'b0;
      power_gate_out  = 1'b0;
      ctx_flush_out   = 1'b0;
      supply_out      = `SUPPLY_ACTIVE;
      case (state_in)
         pkg_idle_pkg::core_running: begin
            clk_run_out = 1'b1;
         end
         pkg_idle_pkg::core_enhanced_halt: begin
            low_freq_out = 1'b1;
            supply_out   = `SUPPLY_MIN_OP;
         end
         pkg_idle_pkg::core_flushed_retention: begin
            cache_flush_out = 1'b1;
            low_freq_out    = 1'b1;
            supply_out      = ret_supply_in;
         end
         pkg_idle_pkg::core_power_gated,
         pkg_idle_pkg::core_power_gated_deep: begin
            pll_on_out      = 1'b0;
            cache_flush_out = 1'b1;
            power_gate_out  = 1'b1;
            ctx_flush_out   = 1'b1;
            low_freq_out    = 1'b1;
            supply_out      = ret_supply_in;
         end
         default: begin
            clk_run_out = 1'b0;
         end
      endcase
   end
endmodule : core_idle_decode
`default_nettype wire

// ===== design/package_core_idle_state_control.sv
// package idle state resolution from core idle states and platform limits
`default_nettype none
`include "pkg_idle_params.svh"
module package_core_idle_state_control (
   // clock and reset
   input  wire logic                                 core_clk_in,
   input  wire logic                                 reset_n_in,
   input  wire logic                                 clk_en_in,
   // core idle states, packed one per core
   input  wire logic [`NUM_CORES*`CORE_STATE_W-1:0]  core_state_in,
   // platform limiting factors
   input  wire logic                                 io_hub_snoop_pend_in,
   input  wire logic                                 io_hub_access_pend_in,
   input  wire logic                                 int_latency_block_in,
   input  wire logic                                 sideband_busy_in,
   input  wire logic                                 config_block_in,
   input  wire logic                                 cache_ways_open_in,
   input  wire logic [`LAT_W-1:0]                    snoop_lat_in,
   input  wire logic [`LAT_W-1:0]                    int_lat_in,
   input  wire logic [`LAT_W-1:0]                    nonsnoop_lat_in,
   // memory power management
   input  wire logic                                 mem_ranks_idle_in,
   input  wire logic                                 self_refresh_req_in,
   input  wire logic                                 suspend_req_in,
   // package outputs
   output logic [`PKG_STATE_W-1:0]                   pkg_state_out,
   output logic                                      pll_on_out,
   output logic                                      min_freq_out,
   output logic [`SUPPLY_W-1:0]                      pkg_supply_out,
   output logic                                      resume_low_freq_out,
   // per-core actions
   output logic [`NUM_CORES-1:0]                     core_clk_run_out,
   output logic [`NUM_CORES-1:0]                     core_pll_on_out,
   output logic [`NUM_CORES-1:0]                     core_cache_flush_out,
   output logic [`NUM_CORES-1:0]                     core_low_freq_out,
   output logic [`NUM_CORES-1:0]                     core_power_gate_out,
   output logic [`NUM_CORES-1:0]                     core_ctx_flush_out,
   output logic [`NUM_CORES*`SUPPLY_W-1:0]           core_supply_out,
   // memory
   output logic                                      mem_clk_en_out,
   output logic                                      mem_self_refresh_out,
   output logic                                      ctx_in_memory_out
);
   // limiting inputs come from other domains: two-flop synchronisers
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic [NSYNC-1:0] async_bus;
   assign async_bus = {io_hub_snoop_pend_in, io_hub_access_pend_in, int_latency_block_in,
                       sideband_busy_in, config_block_in, cache_ways_open_in,
                       mem_ranks_idle_in, self_refresh_req_in, suspend_req_in};
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (clk_en_in) begin
         sync1_reg <= async_bus;
         sync2_reg <= sync1_reg;
      end
   end
   logic snoop_s, access_s, intb_s, side_s, cfg_s, ways_s, ranks_s, sr_s, susp_s;
   assign {snoop_s, access_s, intb_s, side_s, cfg_s, ways_s, ranks_s, sr_s, susp_s} = sync2_reg;

   // latency values are quasi-static configuration; sampled twice as well
   logic [`LAT_W-1:0] snoop_lat1_reg, snoop_lat_reg;
   logic [`LAT_W-1:0] int_lat1_reg, int_lat_reg;
   logic [`LAT_W-1:0] ns_lat1_reg, ns_lat_reg;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         snoop_lat1_reg <= '0;
         snoop_lat_reg  <= '0;
         int_lat1_reg   <= '0;
         int_lat_reg    <= '0;
         ns_lat1_reg    <= '0;
         ns_lat_reg     <= '0;
      end else if (clk_en_in) begin
         snoop_lat1_reg <= snoop_lat_in;
         snoop_lat_reg  <= snoop_lat1_reg;
         int_lat1_reg   <= int_lat_in;
         int_lat_reg    <= int_lat1_reg;
         ns_lat1_reg    <= nonsnoop_lat_in;
         ns_lat_reg     <= ns_lat1_reg;
      end
   end

   // smallest allowed exit latency across all requesters
   logic [`LAT_W-1:0] min_lat;
   always_comb begin
      min_lat = snoop_lat_reg;
      if (int_lat_reg < min_lat) begin
         min_lat = int_lat_reg;
      end
      if (ns_lat_reg < min_lat) begin
         min_lat = ns_lat_reg;
      end
   end

   // supply picked from response-time needs: tight latency keeps a higher level
   logic [`SUPPLY_W-1:0] ret_supply;
   always_comb begin
      if (min_lat >= `LAT_RET_DEEP) begin
         ret_supply = `SUPPLY_RET_DEEP;
      end else begin
         ret_supply = `SUPPLY_RET_LIGHT;
      end
   end

   // per-core action decode
   logic [`NUM_CORES-1:0] any_running_v, all_stopped_v, any_flushed_v, all_gated_v;
   genvar g;
   generate
      for (g = 0; g < `NUM_CORES; g++) begin : g_core
         logic [`CORE_STATE_W-1:0] st;
         assign st = core_state_in[g*`CORE_STATE_W +: `CORE_STATE_W];
         core_idle_decode u_dec (
            .state_in        (st),
            .ret_supply_in   (ret_supply),
            .clk_run_out     (core_clk_run_out[g]),
            .pll_on_out      (core_pll_on_out[g]),
            .cache_flush_out (core_cache_flush_out[g]),
            .low_freq_out    (core_low_freq_out[g]),
            .power_gate_out  (core_power_gate_out[g]),
            .ctx_flush_out   (core_ctx_flush_out[g]),
            .supply_out      (core_supply_out[g*`SUPPLY_W +: `SUPPLY_W])
         );
         // coarse depth classes used to find the shallowest core
         assign any_running_v[g] = (st == pkg_idle_pkg::core_running);
         assign all_stopped_v[g] = (st == pkg_idle_pkg::core_flushed_retention) ||
                                   (st == pkg_idle_pkg::core_power_gated) ||
                                   (st == pkg_idle_pkg::core_power_gated_deep);
         assign any_flushed_v[g] = (st == pkg_idle_pkg::core_flushed_retention);
         assign all_gated_v[g]   = (st == pkg_idle_pkg::core_power_gated) ||
                                   (st == pkg_idle_pkg::core_power_gated_deep);
      end
   endgenerate

   logic any_running, all_stopped, any_flushed, all_gated;
   assign any_running = |any_running_v;
   assign all_stopped = &all_stopped_v;
   assign any_flushed = |any_flushed_v;
   assign all_gated   = &all_gated_v;

   // platform holds: any of them keeps the package shallower
   logic snoopable_block, retention_block, deep_block;
   assign snoopable_block = snoop_s | access_s | intb_s | side_s | cfg_s;
   assign retention_block = snoopable_block | (min_lat < `LAT_RET_LIGHT);
   assign deep_block      = retention_block | ways_s | (min_lat < `LAT_RET_DEEP);

   // resolve target; only four codes exist, so nothing deeper than deep retention
   pkg_idle_pkg::pkg_state_t target;
   always_comb begin
      target = pkg_idle_pkg::package_active;
      if (any_running) begin
         target = pkg_idle_pkg::package_active;
      end else if (all_gated && !deep_block) begin
         target = pkg_idle_pkg::package_deep_retention;
      end else if (all_stopped && (any_flushed || all_gated) && !retention_block) begin
         target = pkg_idle_pkg::package_light_retention;
      end else if (all_stopped && !snoopable_block) begin
         target = pkg_idle_pkg::package_snoopable_idle;
      end
   end

   // package state register, re-resolved every enabled cycle
   pkg_idle_pkg::pkg_state_t state_reg;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= pkg_idle_pkg::package_active;
      end else if (clk_en_in) begin
         state_reg <= target;
      end
   end
   assign pkg_state_out = state_reg;

   // package outputs; pll off only in retention when latency budget allows
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pll_on_out     <= 1'b1;
         min_freq_out   <= 1'b0;
         pkg_supply_out <= `SUPPLY_ACTIVE;
      end else if (clk_en_in) begin
         case (target)
            pkg_idle_pkg::package_snoopable_idle: begin
               pll_on_out     <= 1'b1;
               min_freq_out   <= 1'b1;
               pkg_supply_out <= `SUPPLY_MIN_OP;
            end
            pkg_idle_pkg::package_light_retention,
            pkg_idle_pkg::package_deep_retention: begin
               pll_on_out     <= (min_lat < `LAT_PLL_OFF);
               min_freq_out   <= 1'b1;
               pkg_supply_out <= ret_supply;
            end
            default: begin
               pll_on_out     <= 1'b1;
               min_freq_out   <= 1'b0;
               pkg_supply_out <= `SUPPLY_ACTIVE;
            end
         endcase
      end
   end

   // resume flag: leaving any idle state starts at lowest frequency point
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         resume_low_freq_out <= 1'b0;
      end else if (clk_en_in) begin
         resume_low_freq_out <= (state_reg != pkg_idle_pkg::package_active) &&
                                (target == pkg_idle_pkg::package_active);
      end
   end

   // memory clock enable drops after ranks stay idle; self refresh only on request
   logic [`LAT_W-1:0] mem_idle_cnt_reg;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mem_idle_cnt_reg <= '0;
         mem_clk_en_out   <= 1'b1;
      end else if (clk_en_in) begin
         if (!ranks_s) begin
            mem_idle_cnt_reg <= '0;
            mem_clk_en_out   <= 1'b1;
         end else if (mem_idle_cnt_reg == `MEM_IDLE_CYCLES) begin
            mem_clk_en_out   <= 1'b0;
         end else begin
            mem_idle_cnt_reg <= mem_idle_cnt_reg + 8'h01;
         end
      end
   end

   // software-driven self refresh; suspend forces it so memory keeps context
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mem_self_refresh_out <= 1'b0;
         ctx_in_memory_out    <= 1'b0;
      end else if (clk_en_in) begin
         mem_self_refresh_out <= sr_s | susp_s;
         ctx_in_memory_out    <= susp_s;
      end
   end

   // assertions; antecedents of the |=> checks carry clk_en_in because a frozen cycle updates nothing
   a_run_forces_active: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && any_running |=> state_reg == pkg_idle_pkg::package_active)
      else $error("running core did not force active package");
   a_deep_needs_gated: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && !all_gated |=> state_reg != pkg_idle_pkg::package_deep_retention)
      else $error("deep retention without all cores gated");
   a_snoop_blocks_idle: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && snoopable_block |=> state_reg == pkg_idle_pkg::package_active)
      else $error("package idle entered while blocked");
   a_stopped_entry: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && !all_stopped |=> state_reg == pkg_idle_pkg::package_active)
      else $error("package idle with shallow core");
   a_resume_low_freq: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && state_reg != pkg_idle_pkg::package_active && any_running |=> resume_low_freq_out)
      else $error("resume did not select lowest frequency");
   a_resume_one_cycle: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && resume_low_freq_out |=> !resume_low_freq_out)
      else $error("resume pulse longer than one cycle");
   a_snoop_pll_on: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && target == pkg_idle_pkg::package_snoopable_idle |=> pll_on_out && min_freq_out)
      else $error("snoopable idle must keep pll on at min freq");
   a_ways_block_deep: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && ways_s |=> state_reg != pkg_idle_pkg::package_deep_retention)
      else $error("deep retention with cache ways open");
   a_ret_supply_low: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && (target == pkg_idle_pkg::package_light_retention ||
                    target == pkg_idle_pkg::package_deep_retention) |=> pkg_supply_out < `SUPPLY_MIN_OP)
      else $error("retention supply not below minimum operating level");
   a_pll_off_slack: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && target == pkg_idle_pkg::package_deep_retention && min_lat >= `LAT_PLL_OFF |=> !pll_on_out)
      else $error("pll left on in deep retention with latency slack");
   a_gated_supply_low: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      core_power_gate_out[0] |-> core_supply_out[`SUPPLY_W-1:0] < `SUPPLY_MIN_OP)
      else $error("gated core supply not below minimum operating level");
   a_mem_cke_wake: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && !ranks_s |=> mem_clk_en_out)
      else $error("memory clock enable low while ranks busy");
   a_mem_cke_drop: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && ranks_s && mem_idle_cnt_reg == `MEM_IDLE_CYCLES |=> !mem_clk_en_out)
      else $error("memory clock enable kept high after idle time");
   a_valid_pkg_code: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      state_reg inside {pkg_idle_pkg::package_active, pkg_idle_pkg::package_snoopable_idle,
                        pkg_idle_pkg::package_light_retention, pkg_idle_pkg::package_deep_retention})
      else $error("unsupported package state");
   a_suspend_ctx: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && susp_s |=> ctx_in_memory_out && mem_self_refresh_out)
      else $error("suspend without context kept in memory");
endmodule : package_core_idle_state_control
`default_nettype wire

// ===== design/pkg_idle_params.svh
// constants for the package idle state controller
`ifndef PKG_IDLE_PARAMS_SVH
`define PKG_IDLE_PARAMS_SVH
`define NUM_CORES           4
`define CORE_STATE_W        3
`define PKG_STATE_W         3
`define SUPPLY_W            4
`define SUPPLY_ACTIVE       4'hF
`define SUPPLY_MIN_OP       4'h8
`define SUPPLY_RET_LIGHT    4'h6
`define SUPPLY_RET_DEEP     4'h4
`define SUPPLY_GATED        4'h0
`define LAT_W               8
`define LAT_RET_LIGHT       8'h20
`define LAT_RET_DEEP        8'h80
`define LAT_PLL_OFF         8'h40
`define MEM_IDLE_CYCLES     8'h10
`endif

// ===== design/pkg_idle_pkg.sv
// types shared by the package idle state controller
`default_nettype none
package pkg_idle_pkg;
   typedef enum logic [2:0] {
      core_running           = 3'h0,
      core_halt              = 3'h1,
      core_enhanced_halt     = 3'h2,
      core_flushed_retention = 3'h3,
      core_power_gated       = 3'h6,
      core_power_gated_deep  = 3'h7
   } core_state_t;
   typedef enum logic [2:0] {
      package_active          = 3'h0,
      package_snoopable_idle  = 3'h2,
      package_light_retention = 3'h3,
      package_deep_retention  = 3'h6
   } pkg_state_t;
endpackage : pkg_idle_pkg
`default_nettype wire

// ===== tb/core_platform_model.sv
// far-side model: execution cores and platform limit sources feeding the idle controller
`default_nettype none
`include "pkg_idle_params.svh"
module core_platform_model (
   // clock
   input  wire logic                                core_clk_in,
   // settings requested by the bench
   input  wire logic [`NUM_CORES*`CORE_STATE_W-1:0] core_req_in,
   input  wire logic [5:0]                          limit_req_in,
   input  wire logic [`LAT_W-1:0]                   lat_req_in,
   // lines toward the controller
   output var logic [`NUM_CORES*`CORE_STATE_W-1:0]  core_state_out,
   output var logic [5:0]                           limit_out,
   output var logic [`LAT_W-1:0]                    lat_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // known levels from time zero so nothing floats into the synchronisers
   initial begin
      core_state_out = '0;
      limit_out = '0;
      lat_out = 8'hFF;
   end
   // sources move only on the falling edge, well clear of the sampling edge
   always @(negedge core_clk_in) begin
      core_state_out <= core_req_in;
      limit_out <= limit_req_in;
      lat_out <= lat_req_in;
   end
endmodule : core_platform_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the package idle state controller
`default_nettype none
`include "pkg_idle_params.svh"
`define CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CYCLE_LIMIT = 4000;
   // clock, reset and bench requests
   logic                                core_clk_in;
   logic                                reset_n_in;
   logic                                clk_en;
   logic [`NUM_CORES*`CORE_STATE_W-1:0] core_req;
   logic [5:0]                          limit_req;
   logic [`LAT_W-1:0]                   lat_req;
   logic                                mem_idle;
   logic                                self_ref_req;
   logic                                suspend_req;
   // model to controller
   wire logic [`NUM_CORES*`CORE_STATE_W-1:0] core_state;
   wire logic [5:0]                          limits;
   wire logic [`LAT_W-1:0]                   lat;
   // controller outputs
   wire logic [`PKG_STATE_W-1:0]             pkg_state;
   wire logic                                pll_on;
   wire logic                                min_freq;
   wire logic [`SUPPLY_W-1:0]                pkg_supply;
   wire logic                                resume;
   wire logic [`NUM_CORES-1:0]               c_clk, c_pll, c_flush, c_lf, c_pg, c_ctx;
   wire logic [`NUM_CORES*`SUPPLY_W-1:0]     c_supply;
   wire logic                                mem_clk_en;
   wire logic                                self_refresh;
   wire logic                                ctx_mem;
   int                                       n_fail;
   int                                       total_checks;
   int                                       cycles;
   logic [2:0]                               codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

   core_platform_model core_platform_model_i (.core_clk_in(core_clk_in), .core_req_in(core_req),
      .limit_req_in(limit_req), .lat_req_in(lat_req), .core_state_out(core_state), .limit_out(limits),
      .lat_out(lat));
   package_core_idle_state_control package_core_idle_state_control_i (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .clk_en_in(clk_en), .core_state_in(core_state),
      .io_hub_snoop_pend_in(limits[0]), .io_hub_access_pend_in(limits[1]), .int_latency_block_in(limits[2]),
      .sideband_busy_in(limits[3]), .config_block_in(limits[4]), .cache_ways_open_in(limits[5]),
      .snoop_lat_in(lat), .int_lat_in(lat), .nonsnoop_lat_in(lat), .mem_ranks_idle_in(mem_idle),
      .self_refresh_req_in(self_ref_req), .suspend_req_in(suspend_req), .pkg_state_out(pkg_state),
      .pll_on_out(pll_on), .min_freq_out(min_freq), .pkg_supply_out(pkg_supply),
      .resume_low_freq_out(resume), .core_clk_run_out(c_clk), .core_pll_on_out(c_pll),
      .core_cache_flush_out(c_flush), .core_low_freq_out(c_lf), .core_power_gate_out(c_pg),
      .core_ctx_flush_out(c_ctx), .core_supply_out(c_supply), .mem_clk_en_out(mem_clk_en),
      .mem_self_refresh_out(self_refresh), .ctx_in_memory_out(ctx_mem));

   // free-running 250 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   // hang guard: a stuck run counts as a failure
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles >= CYCLE_LIMIT) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (n_fail == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // new request after a rising edge; five falling edges cover the two-flop limit path
   task automatic apply(input logic [11:0] cores, input logic [5:0] lim, input logic [7:0] l);
      @(posedge core_clk_in);
      core_req = cores;
      limit_req = lim;
      lat_req = l;
      repeat (5) @(negedge core_clk_in);
   endtask : apply

   task automatic check_pkg(input logic [2:0] st, input logic pll, input logic mf, input logic [3:0] sup);
      `CHK(pkg_state, st)
      `CHK(pll_on, pll)
      `CHK(min_freq, mf)
      `CHK(pkg_supply, sup)
   endtask : check_pkg

   // every core code on all cores; expected {clk,pll,flush,low_freq,gate,ctx}
   task automatic core_decode();
      logic [5:0] e;
      for (int i = 0; i < 6; i++) begin
         apply({4{codes[i]}}, 6'h00, 8'hFF);
         case (codes[i])
            3'h0: e = 6'b110000;
            3'h1: e = 6'b010000;
            3'h2: e = 6'b010100;
            3'h3: e = 6'b011100;
            default: e = 6'b001111;
         endcase
         `CHK({c_clk, c_pll, c_flush}, {{4{e[5]}}, {4{e[4]}}, {4{e[3]}}})
         `CHK({c_lf, c_pg, c_ctx}, {{4{e[2]}}, {4{e[1]}}, {4{e[0]}}})
         if (codes[i] < 3'h2)
            `CHK(c_supply, {4{`SUPPLY_ACTIVE}})
         else if (codes[i] == 3'h2)
            `CHK(c_supply, {4{`SUPPLY_MIN_OP}})
         else
            for (int j = 0; j < `NUM_CORES; j++)
               `CHK(c_supply[j*4+:4] < `SUPPLY_MIN_OP, 1'b1)
      end
   endtask : core_decode

   // core0 wakes: active and the low-frequency pulse for exactly one cycle
   task automatic wake_core0();
      @(posedge core_clk_in);
      core_req[2:0] = 3'h0;
      repeat (2) @(negedge core_clk_in);
      `CHK(pkg_state, pkg_idle_pkg::package_active)
      `CHK(resume, 1'b1)
      @(negedge core_clk_in);
      `CHK(resume, 1'b0)
   endtask : wake_core0

   task automatic retention_states();
      apply({4{3'h6}}, 6'h00, 8'hFF);
      check_pkg(pkg_idle_pkg::package_deep_retention, 1'b0, 1'b1, `SUPPLY_RET_DEEP);
      wake_core0();
      apply({4{3'h7}}, 6'h00, 8'hFF);
      `CHK(pkg_state, pkg_idle_pkg::package_deep_retention)
      apply({3'h6, 3'h6, 3'h6, 3'h3}, 6'h00, 8'hFF);
      check_pkg(pkg_idle_pkg::package_light_retention, 1'b0, 1'b1, `SUPPLY_RET_DEEP);
      apply({4{3'h6}}, 6'h20, 8'hFF);
      `CHK(pkg_state, pkg_idle_pkg::package_light_retention)
      apply({4{3'h6}}, 6'h00, 8'h30);
      check_pkg(pkg_idle_pkg::package_light_retention, 1'b1, 1'b1, `SUPPLY_RET_LIGHT);
   endtask : retention_states

   task automatic snoopable_and_blocks();
      apply({4{3'h6}}, 6'h00, 8'h10);
      check_pkg(pkg_idle_pkg::package_snoopable_idle, 1'b1, 1'b1, `SUPPLY_MIN_OP);
      wake_core0();
      for (int b = 0; b < 5; b++) begin
         apply({4{3'h3}}, 6'h01 << b, 8'h10);
         check_pkg(pkg_idle_pkg::package_active, 1'b1, 1'b0, `SUPPLY_ACTIVE);
      end
      for (int c = 1; c < 3; c++) begin
         apply({3'h6, 3'h6, 3'h6, 3'(c)}, 6'h00, 8'hFF);
         `CHK(pkg_state, pkg_idle_pkg::package_active)
      end
   endtask : snoopable_and_blocks

   task automatic memory_power();
      @(negedge core_clk_in);
      mem_idle = 1'b1;
      repeat (8) @(negedge core_clk_in);
      `CHK(mem_clk_en, 1'b1)
      repeat (20) @(negedge core_clk_in);
      `CHK(mem_clk_en, 1'b0)
      mem_idle = 1'b0;
      self_ref_req = 1'b1;
      repeat (5) @(negedge core_clk_in);
      `CHK({mem_clk_en, self_refresh, ctx_mem}, 3'b110)
      self_ref_req = 1'b0;
      suspend_req = 1'b1;
      repeat (5) @(negedge core_clk_in);
      `CHK({self_refresh, ctx_mem}, 2'b11)
      suspend_req = 1'b0;
      repeat (5) @(negedge core_clk_in);
      `CHK({self_refresh, ctx_mem}, 2'b00)
   endtask : memory_power

   // clock enable low freezes the package state; raising it re-resolves at once
   task automatic enable_freeze();
      apply({4{3'h6}}, 6'h00, 8'hFF);
      clk_en = 1'b0;
      apply({4{3'h0}}, 6'h00, 8'hFF);
      `CHK({pkg_state, pll_on, resume}, {pkg_idle_pkg::package_deep_retention, 2'b00})
      clk_en = 1'b1;
      @(negedge core_clk_in);
      `CHK({pkg_state, resume}, {pkg_idle_pkg::package_active, 1'b1})
   endtask : enable_freeze

   // reset, then every scenario in turn
   initial begin
      reset_n_in = 1'b0;
      clk_en = 1'b1;
      core_req = '0;
      limit_req = '0;
      lat_req = 8'hFF;
      mem_idle = 1'b0;
      self_ref_req = 1'b0;
      suspend_req = 1'b0;
      n_fail = 0;
      total_checks = 0;
      cycles = 0;
      repeat (16) @(posedge core_clk_in);
      @(negedge core_clk_in);
      check_pkg(pkg_idle_pkg::package_active, 1'b1, 1'b0, `SUPPLY_ACTIVE);
      `CHK({resume, mem_clk_en, self_refresh, ctx_mem}, 4'h4)
      reset_n_in = 1'b1;
      core_decode();
      retention_states();
      snoopable_and_blocks();
      memory_power();
      enable_freeze();
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
